//--- include/temp_mon_cfg.svh
// Register map, field positions, reset values and limits of the temperature monitor.
// Included by both ends, the checker and the bench; definitions only.
`ifndef TEMP_MON_CFG_SVH
`define TEMP_MON_CFG_SVH

`define ADDR_LOCAL_RESULT    8'h00
`define ADDR_REMOTE_UPPER    8'h01
`define ADDR_CONTROL_RD      8'h03
`define ADDR_CONTROL_WR      8'h09
`define ADDR_REMOTE_FRACTION 8'h10

`define RESET_RESULT         8'h00
`define RESET_CONTROL        8'h00
`define RESET_POINTER        8'h00

`define BIT_ALARM_SUPPRESS   7
`define BIT_STANDBY          6
`define BIT_PIN6_FUNCTION    5
`define BIT_RANGE_SELECT     2
`define CONTROL_USED_MASK    8'he4

`define TEMP_OFFSET          11'sh040
`define BINARY_MAX           11'sh07f
`define EXTENDED_MIN         11'sh7c0
`define EXTENDED_MAX         11'sh0bf

`endif

//--- include/temp_mon_pkg.sv
// Types shared by both ends of the temperature monitor register link.
// Assumes the cfg header is on the include path.
package temp_mon_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_POINTER = 2'b01,
        BUS_DATA    = 2'b10
    } bus_state_t;
    typedef logic [7:0] reg_byte_t;
endpackage

//--- include/temp_mon_if.sv
// Byte-level register link between host controller and monitor.
// Assumes the serial bus framing is done outside; one byte per strobe.
`timescale 1ns/1ps
interface temp_mon_if;
    logic       start;      // Frame start pulse
    logic       stop;       // Frame end pulse
    logic       wr_valid;   // Write byte strobe
    logic [7:0] wr_byte;
    logic       rd_req;     // Read byte request pulse
    logic       rd_valid;   // Read byte answer pulse
    logic [7:0] rd_byte;
    modport monitor (input start, stop, wr_valid, wr_byte, rd_req,
                     output rd_valid, rd_byte);
    modport host    (output start, stop, wr_valid, wr_byte, rd_req,
                     input rd_valid, rd_byte);
endinterface

//--- design/temp_monitor.sv
// Result and control registers of a dual-channel temperature monitor.
// Assumes converter results arrive as signed whole/quarter degrees with a strobe.
//
// Functional notes
// R1: Local result byte at 0x00, one degree.
// R2: Remote result: upper 0x01, fraction 0x10.
// R3: Fraction bits 7:6 quarter degrees, rest zero.
// R4: Remote bytes not locked; host reads both.
// R5: Control bit 2 selects extended range.
// R6: New format from next conversion onward.
// R7: Extended registers span -64 to +191.
// R8: Shorted diode keeps last good remote result.
// R9: Binary by default, offset 64 extended.
// R10: Binary scale clamps to 0 and 127.
// R11: Format change leaves limits; host rewrites.
// R12: First write byte loads pointer; rest target.
// R13: Pointer resets to 0x00.
// R14: Results read-only, reset to 0x00.
// R15: Control read 0x03, written 0x09, reset 0.
// R16: Host avoids writing reserved control bits.
// R17: Bit 7 masks alarm unless pin 6 second.
// R18: Bit 6 halts converter in standby.
// R19: Standby keeps bus and alarm outputs live.
// R20: Bit 5 picks pin 6 function.
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module temp_monitor
    import temp_mon_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Host register link
    temp_mon_if.monitor      bus,
    // Converter side
    input  wire logic        conv_valid_in,
    input  wire logic        conv_is_remote_in,
    input  wire logic [10:0] conv_temp_in,       // Signed degrees * 4
    input  wire logic        diode_short_in,
    // Comparator levels from the limit logic
    input  wire logic        alarm_event_in,
    input  wire logic        overtemp_high_in,
    // Outputs
    output logic             converter_run_out,
    output logic             range_extended_out,
    output logic             pin6_n_out,          // Open-drain: 0 pulls low
    output logic             pin6_oe_n_out,
    output logic             bus_rd_valid_out,
    output logic [7:0]       bus_rd_byte_out
);
    reg_byte_t  local_temp_result;
    reg_byte_t  remote_temp_result_upper;
    reg_byte_t  remote_temp_result_fraction;
    reg_byte_t  control;
    reg_byte_t  register_pointer;
    bus_state_t state;
    bus_state_t next_state;

    // Scale a signed quarter-degree value to the selected register format
    function automatic reg_byte_t scale_temp(input logic [10:0] q, input logic ext);
        logic signed [10:0] deg;
        deg = $signed(q) >>> 2;
        if (ext) begin
            if (deg < $signed(`EXTENDED_MIN)) deg = `EXTENDED_MIN;  // R7
            if (deg > $signed(`EXTENDED_MAX)) deg = `EXTENDED_MAX;  // R7
            deg = deg + `TEMP_OFFSET;                               // R9
        end else begin
            if (deg < 11'sd0) deg = 11'sd0;                         // R10
            if (deg > $signed(`BINARY_MAX)) deg = `BINARY_MAX;      // R10
        end
        return deg[7:0];
    endfunction

    // Whole degrees inside the band of the selected scale
    function automatic logic temp_in_band(input logic [10:0] q, input logic ext);
        logic signed [10:0] deg;
        deg = $signed(q) >>> 2;
        if (ext)
            return (deg >= $signed(`EXTENDED_MIN)) && (deg <= $signed(`EXTENDED_MAX));
        return (deg >= 11'sd0) && (deg <= $signed(`BINARY_MAX));
    endfunction

    wire       ext_now       = control[`BIT_RANGE_SELECT];          // R5
    wire       run           = ~control[`BIT_STANDBY];              // R18
    wire       take_result   = conv_valid_in & run;                 // R6
    wire       take_remote   = take_result & conv_is_remote_in & ~diode_short_in; // R8
    wire       take_local    = take_result & ~conv_is_remote_in;
    wire [7:0] next_whole    = scale_temp(conv_temp_in, ext_now);   // R9
    // Clamped values lose the fraction, so it is zeroed at the rails
    wire       in_band       = temp_in_band(conv_temp_in, ext_now); // R10
    wire [7:0] next_fraction = in_band ? {conv_temp_in[1:0], 6'b000000} : 8'h00; // R3

    // Pointer decode shared by the read and write paths
    wire       hit_local     = (register_pointer == `ADDR_LOCAL_RESULT);
    wire       hit_upper     = (register_pointer == `ADDR_REMOTE_UPPER);
    wire       hit_fraction  = (register_pointer == `ADDR_REMOTE_FRACTION);
    wire       hit_ctrl_rd   = (register_pointer == `ADDR_CONTROL_RD);
    wire       hit_ctrl_wr   = (register_pointer == `ADDR_CONTROL_WR);

    // Start and stop outrank a pointer byte in the same cycle; a data byte still lands
    wire       ptr_write     = bus.wr_valid & (state == BUS_POINTER) &
                               ~bus.start & ~bus.stop;              // R12
    wire       data_write    = bus.wr_valid & (state == BUS_DATA);
    wire       ctrl_write    = data_write & hit_ctrl_wr;            // R15
    wire [7:0] next_control  = bus.wr_byte & `CONTROL_USED_MASK;    // R16

    wire       pin6_second   = control[`BIT_PIN6_FUNCTION];         // R20
    wire       alarm_enabled = ~control[`BIT_ALARM_SUPPRESS];       // R17
    wire       next_pin6_low = pin6_second ? overtemp_high_in :
                               (alarm_event_in & alarm_enabled);    // R17

    // Write-only and unmapped addresses read back as zero
    wire [7:0] read_mux =
        hit_local    ? local_temp_result :
        hit_upper    ? remote_temp_result_upper :
        hit_fraction ? remote_temp_result_fraction :
        hit_ctrl_rd  ? control : 8'h00;                             // R15
    wire [7:0] next_rd_byte  = bus.rd_req ? read_mux : bus_rd_byte_out; // R4

    // Frame sequencing; a start always reopens the pointer phase
    always_comb begin
        next_state = state;
        unique case (state)
            BUS_IDLE:    next_state = BUS_IDLE;
            BUS_POINTER: if (bus.wr_valid) next_state = BUS_DATA;
            BUS_DATA:    next_state = BUS_DATA;
            default:     next_state = BUS_IDLE;
        endcase
        if (bus.stop)
            next_state = BUS_IDLE;
        if (bus.start)
            next_state = BUS_POINTER;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            state <= BUS_IDLE;
        else
            state <= next_state;
    end

    // Results are converter-owned; host writes never reach them
    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            local_temp_result <= `RESET_RESULT;                     // R14
        else if (take_local)
            local_temp_result <= next_whole;                        // R1
    end

    // No lock between the remote bytes; the host reads them back to back
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            remote_temp_result_upper    <= `RESET_RESULT;           // R14
            remote_temp_result_fraction <= `RESET_RESULT;           // R14
        end else if (take_remote) begin
            remote_temp_result_upper    <= next_whole;              // R2
            remote_temp_result_fraction <= next_fraction;           // R2
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            register_pointer <= `RESET_POINTER;                     // R13
        else if (ptr_write)
            register_pointer <= bus.wr_byte;                        // R12
    end

    // Limits live outside this block, so a range change rewrites nothing else
    always_ff @(posedge clk_sys_in) begin
        if (rst_in)
            control <= `RESET_CONTROL;                              // R15
        else if (ctrl_write)
            control <= next_control;                                // R11
    end

    // Converter outputs follow the control register
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            converter_run_out  <= 1'b1;
            range_extended_out <= 1'b0;
        end else begin
            converter_run_out  <= run;                              // R18
            range_extended_out <= ext_now;                          // R5
        end
    end

    // Open drain: data stays low, only the enable moves, standby included
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pin6_n_out    <= 1'b0;
            pin6_oe_n_out <= 1'b1;
        end else begin
            pin6_n_out    <= 1'b0;
            pin6_oe_n_out <= ~next_pin6_low;                        // R19
        end
    end

    // Answer one cycle after the request; the byte holds until the next one
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            bus_rd_valid_out <= 1'b0;
            bus_rd_byte_out  <= 8'h00;
        end else begin
            bus_rd_valid_out <= bus.rd_req;                         // R12
            bus_rd_byte_out  <= next_rd_byte;                       // R4
        end
    end

    assign bus.rd_valid = bus_rd_valid_out;
    assign bus.rd_byte  = bus_rd_byte_out;
endmodule // temp_monitor

//--- design/temp_host.sv
// Host-side controller issuing pointer writes, data writes and reads.
// Assumes one command at a time; monitor answers a read one cycle later.
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module temp_host
    import temp_mon_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // Command port
    input  wire logic       cmd_valid_in,
    input  wire logic       cmd_write_in,
    input  wire logic [7:0] cmd_addr_in,
    input  wire logic [7:0] cmd_data_in,
    output logic            cmd_ready_out,
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_data_out,
    // Register link
    temp_mon_if.host        bus
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_START = 3'b001,
        H_PTR   = 3'b010,
        H_DATA  = 3'b011,
        H_READ  = 3'b100,
        H_WAIT  = 3'b101,
        H_STOP  = 3'b110
    } host_state_t;

    host_state_t st;
    logic        is_write;
    reg_byte_t   addr;
    reg_byte_t   data;
    logic        start_q;
    logic        stop_q;
    logic        wr_valid_q;
    reg_byte_t   wr_byte_q;
    logic        rd_req_q;

    // Reserved control bits always written as zero
    wire [7:0] safe_data = (cmd_addr_in == `ADDR_CONTROL_WR) ?
                           (cmd_data_in & `CONTROL_USED_MASK) : cmd_data_in; // R16

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st <= H_IDLE;
            is_write <= 1'b0;
            addr <= 8'h00;
            data <= 8'h00;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_byte_q <= 8'h00;
            rd_req_q <= 1'b0;
            cmd_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 8'h00;
        end else begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
            wr_valid_q <= 1'b0;
            rd_req_q <= 1'b0;
            rsp_valid_out <= 1'b0;
            // Ready must not wait for valid, or a early request would hang
            cmd_ready_out <= (st == H_IDLE);
            unique case (st)
                H_IDLE: if (cmd_valid_in && cmd_ready_out) begin
                    is_write <= cmd_write_in;
                    addr <= cmd_addr_in;
                    data <= safe_data;
                    cmd_ready_out <= 1'b0;
                    start_q <= 1'b1;
                    st <= H_START;
                end
                H_START: begin
                    wr_valid_q <= 1'b1;
                    wr_byte_q <= addr;               // R12
                    st <= H_PTR;
                end
                H_PTR: begin
                    if (is_write) begin
                        wr_valid_q <= 1'b1;
                        wr_byte_q <= data;           // R11
                        st <= H_DATA;
                    end else begin
                        rd_req_q <= 1'b1;
                        st <= H_WAIT;
                    end
                end
                H_DATA: st <= H_STOP;
                H_WAIT: if (bus.rd_valid) begin
                    rsp_valid_out <= 1'b1;
                    rsp_data_out <= bus.rd_byte;
                    st <= H_STOP;
                end
                H_READ: st <= H_STOP;
                H_STOP: begin
                    stop_q <= 1'b1;
                    st <= H_IDLE;
                end
                default: st <= H_IDLE;
            endcase
        end
    end

    assign bus.start    = start_q;
    assign bus.stop     = stop_q;
    assign bus.wr_valid = wr_valid_q;
    assign bus.wr_byte  = wr_byte_q;
    assign bus.rd_req   = rd_req_q;
endmodule // temp_host

//--- test/temp_mon_assertions.sv
// Checker for the host-to-monitor register link.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module temp_mon_assertions (
    // Clock and reset
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    // Link signals
    input wire logic       start,
    input wire logic       stop,
    input wire logic       wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic       rd_req,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_byte
);
    logic       ptr_phase;
    logic [7:0] ptr;
    logic [7:0] ctrl;
    wire        ctrl_rd = rd_valid && ptr == `ADDR_CONTROL_RD;
    wire        mapped  = ptr inside {8'h00, 8'h01, 8'h03, 8'h10};
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // Shadow state rebuilt from link traffic alone, never from the design
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ptr_phase <= 1'b0;
            ptr       <= `RESET_POINTER;
            ctrl      <= `RESET_CONTROL;
        end else if (start || stop) begin
            ptr_phase <= start;
        end else if (wr_valid && ptr_phase) begin
            ptr_phase <= 1'b0;
            ptr       <= wr_byte;
        end else if (wr_valid && ptr == `ADDR_CONTROL_WR) begin
            ctrl <= wr_byte & `CONTROL_USED_MASK;
        end
    end
    a_read_latency: assert property (rd_req |=> rd_valid)
        else $error("read answer late");
    a_no_stray_answer: assert property (rd_valid |-> $past(rd_req))
        else $error("read answer without request");
    a_byte_held: assert property (!rd_valid |-> $stable(rd_byte))
        else $error("read byte moved between answers");
    a_read_after_ptr: assert property (rd_req |-> !ptr_phase)
        else $error("read before pointer byte");
    a_ctrl_readback: assert property (ctrl_rd |-> rd_byte == ctrl)
        else $error("control readback differs");
    a_reserved_zero: assert property (ctrl_rd |-> (rd_byte & 8'h1b) == 8'h00)
        else $error("reserved control bit set");
    a_fraction_form: assert property (rd_valid && ptr == 8'h10 |-> rd_byte[5:0] == 6'h00)
        else $error("fraction low bits not zero");
    a_unmapped_zero: assert property (rd_valid && !mapped |-> rd_byte == 8'h00)
        else $error("unmapped read not zero");
endmodule // temp_mon_assertions

//--- test/temp_result_and_config_regs_test.sv
// Bench: host and monitor joined over the link, driven from the command port.
// Assumes 200 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module temp_result_and_config_regs_test;
    import temp_mon_pkg::*;
    logic       clk_sys, rst, cmd_v, cmd_w, cmd_rdy, rsp_v, conv_v, conv_r, short_d;
    logic       alarm, hot, run, ext, pin_n, pin_oe_n, rd_v, x, s;
    logic [7:0] cmd_a, cmd_d, rsp_d, rd_b;
    logic [10:0] conv_t;
    reg_byte_t  exp_q[$];
    reg_byte_t  e_byte, up, fr, lo;
    int         bad_count, num_checks, i, k, t;
    int         temps[4] = '{-400, -256, 767, 1023};
    logic [8:0] pins[7] = '{9'h000, 9'h101, 9'h040, 9'h1c0, 9'h180, 9'h0a1, 9'h021};
    temp_mon_if link ();
    temp_host u_temp_host (.clk_sys_in(clk_sys), .rst_in(rst), .cmd_valid_in(cmd_v),
        .cmd_write_in(cmd_w), .cmd_addr_in(cmd_a), .cmd_data_in(cmd_d),
        .cmd_ready_out(cmd_rdy), .rsp_valid_out(rsp_v), .rsp_data_out(rsp_d), .bus(link));
    temp_monitor u_temp_monitor (.clk_sys_in(clk_sys), .rst_in(rst), .bus(link),
        .conv_valid_in(conv_v), .conv_is_remote_in(conv_r), .conv_temp_in(conv_t),
        .diode_short_in(short_d), .alarm_event_in(alarm), .overtemp_high_in(hot),
        .converter_run_out(run), .range_extended_out(ext), .pin6_n_out(pin_n),
        .pin6_oe_n_out(pin_oe_n), .bus_rd_valid_out(rd_v), .bus_rd_byte_out(rd_b));
    temp_mon_assertions u_temp_mon_assertions (.clk_sys_in(clk_sys), .rst_in(rst),
        .start(link.start), .stop(link.stop), .wr_valid(link.wr_valid),
        .wr_byte(link.wr_byte), .rd_req(link.rd_req), .rd_valid(link.rd_valid),
        .rd_byte(link.rd_byte));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Responses are read mid-cycle, so register updates have settled
    always @(negedge clk_sys) begin
        if (rsp_v === 1'b1) begin
            e_byte = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
            `CHK(rsp_d, e_byte)
            `CHK(rd_b, e_byte)
        end
    end
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_rdy;
        int n;
        for (n = 0; n < 64; n++) begin
            @(negedge clk_sys);
            if (cmd_rdy === 1'b1) break;
        end
        if (n == 64) begin
            bad_count++;
            give_verdict();
        end
    endtask
    // Holds the command until ready is seen, then waits for idle again
    task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cmd_v <= 1'b1;
        cmd_w <= w;
        cmd_a <= a;
        cmd_d <= d;
        wait_rdy();
        @(posedge clk_sys);
        cmd_v <= 1'b0;
        wait_rdy();
    endtask
    task automatic rd(input logic [7:0] a, input reg_byte_t e);
        exp_q.push_back(e);
        cmd(1'b0, a, 8'h00);
    endtask
    task automatic conv(input logic r, input int tq, input logic sh);
        @(posedge clk_sys);
        conv_v <= 1'b1;
        conv_r <= r;
        conv_t <= tq[10:0];
        short_d <= sh;
        @(posedge clk_sys);
        conv_v <= 1'b0;
    endtask
    // Expected stored bytes; a shorted diode leaves the remote pair alone
    function automatic void model(input logic r, input int tq, input logic sh);
        int d;
        int q;
        d = tq >>> 2;
        q = tq & 3;
        if (x ? d < -64 : d < 0) begin
            d = x ? -64 : 0;
            q = 0;
        end
        if (x ? d > 191 : d > 127) begin
            d = x ? 191 : 127;
            q = 0;
        end
        if (x) d = d + 64;
        if (!r) lo = d[7:0];
        else if (!sh) begin
            up = d[7:0];
            fr = {q[1:0], 6'h00};
        end
    endfunction
    initial begin
        {cmd_v, cmd_w, cmd_a, cmd_d, conv_v, conv_r, conv_t, short_d, alarm, hot} = '0;
        {up, fr, lo, bad_count, num_checks, x} = '0;
        rst = 1'b1;
        void'($urandom(32'h807c));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        `CHK(run, 1'b1)
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h20, 8'h00);
        cmd(1'b1, 8'h00, 8'h5a);
        rd(8'h00, 8'h00);
        cmd(1'b1, 8'h09, 8'hff);
        rd(8'h03, 8'he4);
        `CHK(run, 1'b0)
        conv(1'b0, 40, 1'b0);
        rd(8'h00, 8'h00);
        for (i = 0; i < 2; i++) begin
            x = i[0];
            cmd(1'b1, 8'h09, x ? 8'h04 : 8'h00);
            `CHK(ext, x)
            for (k = 0; k < 9; k++) begin
                t = k < 4 ? temps[k] : int'($urandom_range(2047)) - 1024;
                s = $urandom_range(3) == 0;
                conv(k[0], t, s);
                model(k[0], t, s);
                rd(8'h00, lo);
                rd(8'h01, up);
                rd(8'h10, fr);
            end
        end
        foreach (pins[j]) begin
            cmd(1'b1, 8'h09, pins[j][7:0]);
            @(posedge clk_sys);
            alarm <= ~pins[j][0];
            hot <= pins[j][0];
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK(pin_oe_n, pins[j][8])
            `CHK(pin_n, 1'b0)
        end
        for (i = 0; i < 32 && exp_q.size() > 0; i++) @(negedge clk_sys);
        if (exp_q.size() > 0) bad_count++;
        give_verdict();
    end
endmodule // temp_result_and_config_regs_test
